// ---- rtl/rmc_pkg.sv ----
`default_nettype none

package rmc_pkg;

  localparam int REG_COUNT = 16;
  localparam int ADDR_W = 4;

  localparam logic [3:0] ADDR_PRIMARY_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SECONDARY_CTRL = 4'h1;
  localparam logic [3:0] ADDR_SECONDS = 4'h2;
  localparam logic [3:0] ADDR_MINUTES = 4'h3;
  localparam logic [3:0] ADDR_HOURS = 4'h4;
  localparam logic [3:0] ADDR_DAY_OF_MONTH = 4'h5;
  localparam logic [3:0] ADDR_DAY_OF_WEEK = 4'h6;
  localparam logic [3:0] ADDR_MONTH_CENTURY = 4'h7;
  localparam logic [3:0] ADDR_YEAR = 4'h8;
  localparam logic [3:0] ADDR_ALARM_MINUTE = 4'h9;
  localparam logic [3:0] ADDR_ALARM_HOUR = 4'ha;
  localparam logic [3:0] ADDR_ALARM_DAY = 4'hb;
  localparam logic [3:0] ADDR_ALARM_WEEKDAY = 4'hc;
  localparam logic [3:0] ADDR_SQUARE_WAVE = 4'hd;
  localparam logic [3:0] ADDR_COUNTDOWN_CTRL = 4'he;
  localparam logic [3:0] ADDR_COUNTDOWN_VALUE = 4'hf;

  // field positions
  localparam int EXT_CLOCK_TEST_BIT = 7;
  localparam int STOP_BIT = 5;
  localparam int FACTORY_TEST_BIT = 3;
  localparam int PULSE_MODE_BIT = 4;
  localparam int ALARM_FLAG_BIT = 3;
  localparam int TIMER_FLAG_BIT = 2;
  localparam int ALARM_INT_EN_BIT = 1;
  localparam int TIMER_INT_EN_BIT = 0;
  localparam int VOLTAGE_LOW_BIT = 7;
  localparam int CENTURY_BIT = 7;
  localparam int MATCH_EN_BIT = 7;
  localparam int SQ_EN_BIT = 7;
  localparam int RUN_EN_BIT = 7;

  // implemented bits per register, index = address
  localparam logic [7:0] IMPL_MASK [REG_COUNT] = '{
    8'ha8, 8'h1f, 8'hff, 8'h7f, 8'h3f, 8'h3f, 8'h07, 8'h9f,
    8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h83, 8'h83, 8'hff
  };

  localparam logic [7:0] RESET_VAL [REG_COUNT] = '{
    8'h08, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01,
    8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h03, 8'h00
  };

  // bcd limits
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] WDAY_MAX = 8'h06;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;

  // divider: enable arrives at twice the crystal rate
  localparam int OSC_TICK_HZ = 65536;
  localparam int DIV_W = 16;
  localparam int TAP_1024HZ = 5;
  localparam int TAP_32HZ = 10;
  localparam int TAP_1HZ = 15;

  localparam logic [1:0] SQ_SEL_32K = 2'h0;
  localparam logic [1:0] SQ_SEL_1024 = 2'h1;
  localparam logic [1:0] SQ_SEL_32 = 2'h2;
  localparam logic [1:0] SQ_SEL_1 = 2'h3;

endpackage : rmc_pkg

`default_nettype wire

// ---- rtl/rmc_divider.sv ----
`default_nettype none

module rmc_divider (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_osc_tick,
  input wire logic i_stop,
  input wire logic i_sq_en,
  input wire logic [1:0] i_sq_sel,
  output logic o_sec_tick,
  output logic o_square_wave
);

  logic [rmc_pkg::DIV_W-1:0] chain_reg;
  logic [rmc_pkg::DIV_W-1:0] chain_next;
  logic crystal_phase_reg;
  logic wrap;
  logic sq_sel_level;

  // crystal phase lives outside the chain so stop leaves it running
  assign chain_next = {chain_reg[rmc_pkg::DIV_W-1:1] + 15'h0001, 1'b0};
  assign wrap = i_osc_tick && (&chain_reg[rmc_pkg::DIV_W-1:1]) && crystal_phase_reg;

  assign sq_sel_level =
    (i_sq_sel == rmc_pkg::SQ_SEL_32K) ? crystal_phase_reg :
    (i_sq_sel == rmc_pkg::SQ_SEL_1024) ? chain_reg[rmc_pkg::TAP_1024HZ] :
    (i_sq_sel == rmc_pkg::SQ_SEL_32) ? chain_reg[rmc_pkg::TAP_32HZ] :
    chain_reg[rmc_pkg::TAP_1HZ];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      crystal_phase_reg <= 1'b0;
    end else if (i_osc_tick) begin
      crystal_phase_reg <= ~crystal_phase_reg;
    end
  end

  // one clock only, so the clear acts on the next edge and holds while stop is set
  always_ff @(posedge i_clk) begin
    if (i_rst || i_stop) begin
      chain_reg <= '0;
    end else if (i_osc_tick && crystal_phase_reg) begin
      chain_reg <= chain_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sec_tick <= 1'b0;
      o_square_wave <= 1'b0;
    end else begin
      o_sec_tick <= wrap && !i_stop;
      o_square_wave <= i_sq_en && sq_sel_level;
    end
  end

endmodule : rmc_divider

`default_nettype wire

// ---- rtl/rmc_regmap.sv ----
`default_nettype none

module rmc_regmap (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_osc_tick,
  input wire logic i_acc_begin,
  input wire logic [3:0] i_acc_addr,
  input wire logic i_acc_active,
  input wire logic i_wr_strobe,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_strobe,
  input wire logic i_alarm_event,
  input wire logic i_timer_event,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic [3:0] o_pointer,
  output logic o_frozen,
  output logic o_sec_tick,
  output logic o_square_wave_output,
  output logic o_ext_clock_test_mode,
  output logic o_factory_test_mode,
  output logic o_timer_int_pulse_mode,
  output logic o_alarm_flag,
  output logic o_timer_flag,
  output logic o_alarm_int_en,
  output logic o_timer_int_en,
  output logic o_countdown_run_en,
  output logic [1:0] o_countdown_source_sel,
  output logic [7:0] o_countdown_value
);

  // bcd increment with wrap: returns {carry, value}
  function automatic logic [8:0] bcd_inc(
    input logic [7:0] v,
    input logic [7:0] vmax,
    input logic [7:0] vmin
  );
    logic [7:0] r;
    logic c;
    c = 1'b0;
    if (v >= vmax) begin
      r = vmin;
      c = 1'b1;
    end else if (v[3:0] >= 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return {c, r};
  endfunction : bcd_inc

  // two-digit bcd year divisible by four
  function automatic logic leap_year(input logic [7:0] y);
    logic ok;
    ok = 1'b0;
    if (!y[4]) begin
      ok = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end else begin
      ok = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return ok;
  endfunction : leap_year

  function automatic logic [7:0] month_days(
    input logic [7:0] m,
    input logic [7:0] y
  );
    logic [7:0] d;
    d = rmc_pkg::DAYS_31;
    case (m)
      8'h02: begin
        d = leap_year(y) ? rmc_pkg::DAYS_29 : rmc_pkg::DAYS_28;
      end
      8'h04, 8'h06, 8'h09, 8'h11: begin
        d = rmc_pkg::DAYS_30;
      end
      default: begin
        d = rmc_pkg::DAYS_31;
      end
    endcase
    return d;
  endfunction : month_days

  logic [7:0] regs_reg [rmc_pkg::REG_COUNT];
  logic [3:0] ptr_reg;
  logic [3:0] ptr_next;
  logic pending_reg;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic frozen_reg;

  // control fields straight out of the register file
  logic stop_bit;
  logic sq_en;
  logic [1:0] sq_sel;
  logic div_sec_tick;

  assign stop_bit = regs_reg[rmc_pkg::ADDR_PRIMARY_CTRL][rmc_pkg::STOP_BIT];
  assign sq_en = regs_reg[rmc_pkg::ADDR_SQUARE_WAVE][rmc_pkg::SQ_EN_BIT];
  assign sq_sel = regs_reg[rmc_pkg::ADDR_SQUARE_WAVE][1:0];

  rmc_divider u_divider (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_osc_tick(i_osc_tick),
    .i_stop(stop_bit),
    .i_sq_en(sq_en),
    .i_sq_sel(sq_sel),
    .o_sec_tick(div_sec_tick),
    .o_square_wave(o_square_wave_output)
  );

  // pointer: a new start address wins over a byte strobe in the same cycle
  logic byte_done;
  assign byte_done = i_wr_strobe || i_rd_strobe;
  assign ptr_next = i_acc_begin ? i_acc_addr :
                    byte_done ? ptr_reg + 4'h1 :
                    ptr_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptr_reg <= 4'h0;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // freeze handling: one tick may wait; a second tick during the same access
  // releases the waiting one, so the counters never lag more than a second
  logic apply_tick;
  logic pending_next;
  assign apply_tick = i_acc_active ? (div_sec_tick && pending_reg) :
                      (div_sec_tick || pending_reg);
  assign pending_next = i_acc_active ? (pending_reg || div_sec_tick) : 1'b0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pending_reg <= 1'b0;
      frozen_reg <= 1'b0;
    end else begin
      pending_reg <= pending_next;
      frozen_reg <= i_acc_active;
    end
  end

  // time advance, all in bcd
  logic [7:0] sec_cur;
  logic [7:0] min_cur;
  logic [7:0] hour_cur;
  logic [7:0] date_cur;
  logic [7:0] wday_cur;
  logic [7:0] mon_cur;
  logic [7:0] year_cur;
  logic [8:0] sec_inc;
  logic [8:0] min_inc;
  logic [8:0] hour_inc;
  logic [8:0] date_inc;
  logic [8:0] wday_inc;
  logic [8:0] mon_inc;
  logic [8:0] year_inc;
  logic c_sec;
  logic c_min;
  logic c_hour;
  logic c_mon;

  assign sec_cur = {1'b0, regs_reg[rmc_pkg::ADDR_SECONDS][6:0]};
  assign min_cur = regs_reg[rmc_pkg::ADDR_MINUTES];
  assign hour_cur = regs_reg[rmc_pkg::ADDR_HOURS];
  assign date_cur = regs_reg[rmc_pkg::ADDR_DAY_OF_MONTH];
  assign wday_cur = regs_reg[rmc_pkg::ADDR_DAY_OF_WEEK];
  assign mon_cur = {3'h0, regs_reg[rmc_pkg::ADDR_MONTH_CENTURY][4:0]};
  assign year_cur = regs_reg[rmc_pkg::ADDR_YEAR];

  assign sec_inc = bcd_inc(sec_cur, rmc_pkg::SEC_MAX, rmc_pkg::BCD_ZERO);
  assign min_inc = bcd_inc(min_cur, rmc_pkg::MIN_MAX, rmc_pkg::BCD_ZERO);
  assign hour_inc = bcd_inc(hour_cur, rmc_pkg::HOUR_MAX, rmc_pkg::BCD_ZERO);
  assign date_inc = bcd_inc(date_cur, month_days(mon_cur, year_cur), rmc_pkg::BCD_ONE);
  assign wday_inc = bcd_inc(wday_cur, rmc_pkg::WDAY_MAX, rmc_pkg::BCD_ZERO);
  assign mon_inc = bcd_inc(mon_cur, rmc_pkg::MONTH_MAX, rmc_pkg::BCD_ONE);
  assign year_inc = bcd_inc(year_cur, rmc_pkg::YEAR_MAX, rmc_pkg::BCD_ZERO);

  assign c_sec = apply_tick && sec_inc[8];
  assign c_min = c_sec && min_inc[8];
  assign c_hour = c_min && hour_inc[8];
  assign c_mon = c_hour && date_inc[8] && mon_inc[8];

  // write decode; unimplemented bits are dropped on the way in
  logic wr_en;
  logic [7:0] wr_masked;
  assign wr_en = i_wr_strobe && !i_acc_begin;
  assign wr_masked = i_wr_data & rmc_pkg::IMPL_MASK[ptr_reg];

  // flags: hardware set wins over a host clear in the same cycle
  logic wr_ctrl2;
  logic alarm_flag_next;
  logic timer_flag_next;
  logic [7:0] ctrl2_cur;
  assign wr_ctrl2 = wr_en && (ptr_reg == rmc_pkg::ADDR_SECONDARY_CTRL);
  assign ctrl2_cur = regs_reg[rmc_pkg::ADDR_SECONDARY_CTRL];
  assign alarm_flag_next = i_alarm_event ||
    (ctrl2_cur[rmc_pkg::ALARM_FLAG_BIT] &&
     !(wr_ctrl2 && !i_wr_data[rmc_pkg::ALARM_FLAG_BIT]));
  assign timer_flag_next = i_timer_event ||
    (ctrl2_cur[rmc_pkg::TIMER_FLAG_BIT] &&
     !(wr_ctrl2 && !i_wr_data[rmc_pkg::TIMER_FLAG_BIT]));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < rmc_pkg::REG_COUNT; i++) begin
        regs_reg[i] <= rmc_pkg::RESET_VAL[i];
      end
    end else begin
      // time counters advance first, a host write to the same byte wins
      if (apply_tick) begin
        regs_reg[rmc_pkg::ADDR_SECONDS][6:0] <= sec_inc[6:0];
      end
      if (c_sec) begin
        regs_reg[rmc_pkg::ADDR_MINUTES] <= min_inc[7:0];
      end
      if (c_min) begin
        regs_reg[rmc_pkg::ADDR_HOURS] <= hour_inc[7:0];
      end
      if (c_hour) begin
        regs_reg[rmc_pkg::ADDR_DAY_OF_MONTH] <= date_inc[7:0];
        regs_reg[rmc_pkg::ADDR_DAY_OF_WEEK] <= wday_inc[7:0];
      end
      if (c_hour && date_inc[8]) begin
        regs_reg[rmc_pkg::ADDR_MONTH_CENTURY][4:0] <= mon_inc[4:0];
      end
      if (c_mon) begin
        regs_reg[rmc_pkg::ADDR_YEAR] <= year_inc[7:0];
      end
      // a century bit flips when the year rolls 99 to 00
      if (c_mon && year_inc[8]) begin
        regs_reg[rmc_pkg::ADDR_MONTH_CENTURY][rmc_pkg::CENTURY_BIT] <=
          ~regs_reg[rmc_pkg::ADDR_MONTH_CENTURY][rmc_pkg::CENTURY_BIT];
      end
      if (wr_en && !wr_ctrl2) begin
        regs_reg[ptr_reg] <= wr_masked;
      end
      if (wr_ctrl2) begin
        regs_reg[rmc_pkg::ADDR_SECONDARY_CTRL][4] <= i_wr_data[rmc_pkg::PULSE_MODE_BIT];
        regs_reg[rmc_pkg::ADDR_SECONDARY_CTRL][1:0] <= i_wr_data[1:0];
      end
      regs_reg[rmc_pkg::ADDR_SECONDARY_CTRL][rmc_pkg::ALARM_FLAG_BIT] <= alarm_flag_next;
      regs_reg[rmc_pkg::ADDR_SECONDARY_CTRL][rmc_pkg::TIMER_FLAG_BIT] <= timer_flag_next;
    end
  end

  // read path: data of the byte at the pointer, one cycle after the strobe
  logic rd_en;
  logic [7:0] rd_word;
  assign rd_en = i_rd_strobe && !i_acc_begin;
  assign rd_word = regs_reg[ptr_reg] & rmc_pkg::IMPL_MASK[ptr_reg];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_en;
      if (rd_en) begin
        rd_data_reg <= rd_word;
      end
    end
  end

  // the test bits only steer outside logic; leaving them set is the host's
  // problem, this block keeps time regardless
  assign o_ext_clock_test_mode =
    regs_reg[rmc_pkg::ADDR_PRIMARY_CTRL][rmc_pkg::EXT_CLOCK_TEST_BIT];
  assign o_factory_test_mode =
    regs_reg[rmc_pkg::ADDR_PRIMARY_CTRL][rmc_pkg::FACTORY_TEST_BIT];
  assign o_timer_int_pulse_mode = ctrl2_cur[rmc_pkg::PULSE_MODE_BIT];
  assign o_alarm_flag = ctrl2_cur[rmc_pkg::ALARM_FLAG_BIT];
  assign o_timer_flag = ctrl2_cur[rmc_pkg::TIMER_FLAG_BIT];
  assign o_alarm_int_en = ctrl2_cur[rmc_pkg::ALARM_INT_EN_BIT];
  assign o_timer_int_en = ctrl2_cur[rmc_pkg::TIMER_INT_EN_BIT];
  assign o_countdown_run_en =
    regs_reg[rmc_pkg::ADDR_COUNTDOWN_CTRL][rmc_pkg::RUN_EN_BIT];
  assign o_countdown_source_sel = regs_reg[rmc_pkg::ADDR_COUNTDOWN_CTRL][1:0];
  assign o_countdown_value = regs_reg[rmc_pkg::ADDR_COUNTDOWN_VALUE];
  assign o_rd_data = rd_data_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_pointer = ptr_reg;
  assign o_frozen = frozen_reg;
  assign o_sec_tick = div_sec_tick;

endmodule : rmc_regmap

`default_nettype wire

// ---- tb/rmc_props.sv ----
`default_nettype none

module rmc_props (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_acc_begin,
  input wire logic [3:0] i_acc_addr,
  input wire logic i_acc_active,
  input wire logic i_wr_strobe,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_strobe,
  input wire logic i_alarm_event,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic [3:0] o_pointer,
  input wire logic o_frozen,
  input wire logic o_alarm_flag,
  input wire logic o_timer_flag,
  input wire logic [7:0] o_countdown_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take_rd;
  logic take_any;
  logic [1:0] flags;
  // a begin in the same cycle swallows any strobe
  assign take_rd = i_rd_strobe && !i_acc_begin;
  assign take_any = (i_rd_strobe || i_wr_strobe) && !i_acc_begin;
  assign flags = {o_alarm_flag, o_timer_flag};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_ptr_step;
    take_any |=> o_pointer == $past(o_pointer) + 4'h1;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step");
  property p_ptr_wrap;
    take_any && o_pointer == 4'hf |=> o_pointer == 4'h0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");
  property p_ptr_load;
    i_acc_begin |=> o_pointer == $past(i_acc_addr);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
  property p_rd_pulse;
    take_rd |=> o_rd_valid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read not answered");
  property p_rd_quiet;
    !take_rd |=> !o_rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("spurious read valid");
  property p_freeze;
    i_acc_active |=> o_frozen;
  endproperty
  a_freeze: assert property (p_freeze) else $error("counters not frozen");
  property p_alarm_set;
    i_alarm_event |=> o_alarm_flag;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");
  property p_flag_hold;
    o_alarm_flag && !(i_wr_strobe && !i_acc_begin && o_pointer == 4'h1 && !i_wr_data[3])
      |=> o_alarm_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("alarm flag dropped");
  property p_ctrl1_rsv;
    take_rd && o_pointer == 4'h0 |=> (o_rd_data & 8'h57) == 8'h00;
  endproperty
  a_ctrl1_rsv: assert property (p_ctrl1_rsv) else $error("reserved bits not zero");
  property p_ctrl2_rd;
    take_rd && o_pointer == 4'h1 |=> o_rd_data[3:2] == $past(flags) && o_rd_data[7:5] == 3'h0;
  endproperty
  a_ctrl2_rd: assert property (p_ctrl2_rd) else $error("flag read wrong");
  property p_cnt_rd;
    take_rd && o_pointer == 4'hf |=> o_rd_data == $past(o_countdown_value);
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("countdown read wrong");
endmodule : rmc_props

bind rmc_regmap rmc_props u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_acc_begin(i_acc_begin), .i_acc_addr(i_acc_addr),
  .i_acc_active(i_acc_active), .i_wr_strobe(i_wr_strobe), .i_wr_data(i_wr_data),
  .i_rd_strobe(i_rd_strobe), .i_alarm_event(i_alarm_event), .o_rd_data(o_rd_data),
  .o_rd_valid(o_rd_valid), .o_pointer(o_pointer), .o_frozen(o_frozen),
  .o_alarm_flag(o_alarm_flag), .o_timer_flag(o_timer_flag),
  .o_countdown_value(o_countdown_value)
);

`default_nettype wire

// ---- tb/rmc_host.sv ----
`default_nettype none

module rmc_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid,
  output var logic o_acc_begin,
  output var logic o_acc_active,
  output var logic [3:0] o_acc_addr,
  output var logic o_wr_strobe,
  output var logic [7:0] o_wr_data,
  output var logic o_rd_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ptr;

  initial begin
    o_acc_begin = 1'b0;
    o_acc_active = 1'b0;
    o_acc_addr = 4'h0;
    o_wr_strobe = 1'b0;
    o_wr_data = 8'h00;
    o_rd_strobe = 1'b0;
    ptr = 4'h0;
  end

  task start(input logic [3:0] a);
    @(negedge i_clk);
    o_acc_active = 1'b1;
    o_acc_begin = 1'b1;
    o_acc_addr = a;
    ptr = a;
    @(negedge i_clk);
    o_acc_begin = 1'b0;
    o_acc_addr = ~a;
  endtask : start

  task wr(input logic [7:0] d);
    @(negedge i_clk);
    o_wr_strobe = 1'b1;
    // test and reserved bits of both control bytes always go out as zero
    if (ptr == 4'h0) o_wr_data = d & 8'h20;
    else if (ptr == 4'h1) o_wr_data = d & 8'h1f;
    else o_wr_data = d;
    @(negedge i_clk);
    o_wr_strobe = 1'b0;
    o_wr_data = ~o_wr_data;
    ptr = ptr + 4'h1;
  endtask : wr

  task rd(output logic [7:0] d);
    @(negedge i_clk);
    o_rd_strobe = 1'b1;
    @(negedge i_clk);
    o_rd_strobe = 1'b0;
    d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hxx;
    ptr = ptr + 4'h1;
  endtask : rd

  task finish;
    @(negedge i_clk);
    o_acc_active = 1'b0;
  endtask : finish
endmodule : rmc_host

`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic osc = 1'b0;
  logic aev = 1'b0;
  logic tev = 1'b0;
  logic fast = 1'b0;
  wire logic acc_begin, acc_active, wr_stb, rd_stb, rd_valid, sec, sqw, aflag, tflag;
  wire logic frz, ext_t, fac_t, pmode, alarm_en, timer_en, run_en;
  wire logic [1:0] src_sel;
  wire logic [3:0] acc_addr, ptr_q;
  wire logic [7:0] wr_data, rd_data, cnt_val;
  int bad_count = 0;
  int check_count = 0;
  int n;
  logic prev;
  logic [3:0] a;
  logic [7:0] d;
  logic [7:0] dv [16];

  rmc_host host (.i_clk(i_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .o_acc_begin(acc_begin), .o_acc_active(acc_active), .o_acc_addr(acc_addr),
    .o_wr_strobe(wr_stb), .o_wr_data(wr_data), .o_rd_strobe(rd_stb));

  rmc_regmap uut (.i_clk(i_clk), .i_rst(i_rst), .i_osc_tick(osc), .i_acc_begin(acc_begin),
    .i_acc_addr(acc_addr), .i_acc_active(acc_active), .i_wr_strobe(wr_stb),
    .i_wr_data(wr_data), .i_rd_strobe(rd_stb), .i_alarm_event(aev), .i_timer_event(tev),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_pointer(ptr_q), .o_frozen(frz),
    .o_sec_tick(sec), .o_square_wave_output(sqw), .o_ext_clock_test_mode(ext_t),
    .o_factory_test_mode(fac_t), .o_timer_int_pulse_mode(pmode), .o_alarm_flag(aflag),
    .o_timer_flag(tflag), .o_alarm_int_en(alarm_en), .o_timer_int_en(timer_en),
    .o_countdown_run_en(run_en), .o_countdown_source_sel(src_sel),
    .o_countdown_value(cnt_val));

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // sparse crystal pulses keep the second counter far from a carry
  always @(negedge i_clk) osc <= fast ? 1'b1 : ($urandom_range(3) == 0);

  function automatic logic [7:0] exp_byte(input logic [3:0] ad, input logic [7:0] dt);
    logic [7:0] e;
    e = dt & rmc_pkg::IMPL_MASK[ad];
    if (ad == 4'h0) e = e & 8'h20;
    if (ad == 4'h1) e = e & 8'h13;
    return e;
  endfunction : exp_byte

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (100000) @(posedge i_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h0699ec08));
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    host.start(4'h0);
    for (int i = 0; i < 17; i++) begin
      host.rd(d);
      chk8(d, rmc_pkg::RESET_VAL[i % 16]);
    end
    chk8({4'h0, ptr_q}, 8'h01);
    chk8({ext_t, 3'h0, fac_t, 3'h0}, rmc_pkg::RESET_VAL[0]);
    chk8({3'h0, pmode, 2'h0, alarm_en, timer_en}, rmc_pkg::RESET_VAL[1]);
    chk8({run_en, 5'h0, src_sel}, rmc_pkg::RESET_VAL[14]);
    chk8(cnt_val, rmc_pkg::RESET_VAL[15]);
    host.finish();
    repeat (4) begin
      a = 4'($urandom());
      host.start(a);
      for (int i = 0; i < 16; i++) begin
        dv[i] = 8'($urandom());
        host.wr(dv[i]);
      end
      host.start(a);
      for (int i = 0; i < 16; i++) begin
        host.rd(d);
        chk8(d, exp_byte(a + 4'(i), dv[i]));
      end
      chk8({run_en, 5'h0, src_sel}, exp_byte(4'he, dv[4'(4'he - a)]));
      chk8(cnt_val, exp_byte(4'hf, dv[4'(4'hf - a)]));
      chk8({6'h0, ext_t, fac_t}, 8'h00);
      chk8({7'h0, frz}, 8'h01);
      host.finish();
    end
    @(negedge i_clk);
    aev = 1'b1;
    tev = 1'b1;
    @(negedge i_clk);
    aev = 1'b0;
    tev = 1'b0;
    chk8({6'h0, aflag, tflag}, 8'h03);
    foreach (dv[i]) if (i < 2) begin
      host.start(4'h1);
      host.wr(i == 0 ? 8'h0c : 8'h00);
      host.start(4'h1);
      host.rd(d);
      host.finish();
      chk8(d & 8'h0c, i == 0 ? 8'h0c : 8'h00);
    end
    host.start(4'h0);
    foreach (dv[i]) if (i < 5) begin
      host.wr(i == 0 ? 8'h20 : (i == 1 ? 8'h13 : (i == 4 ? 8'h05 : 8'h59)));
    end
    host.start(4'hd);
    host.wr(8'h80);
    host.finish();
    chk8({5'h0, pmode, alarm_en, timer_en}, 8'h07);
    fast = 1'b1;
    n = 0;
    prev = sqw;
    repeat (64) begin
      @(negedge i_clk);
      if (sqw !== prev) n++;
      if (sec === 1'b1) n += 1000;
      prev = sqw;
    end
    chk8({7'h0, n > 0 && n < 1000}, 8'h01);
    host.start(4'h0);
    host.wr(8'h00);
    n = 0;
    while (sec !== 1'b1 && n < 70000) begin
      @(negedge i_clk);
      n++;
    end
    chk8({7'h0, n > 65500 && n < 65560}, 8'h01);
    host.start(4'h2);
    host.rd(d);
    chk8(d, 8'h59);
    chk8({7'h0, frz}, 8'h01);
    host.finish();
    repeat (3) @(negedge i_clk);
    chk8({7'h0, frz}, 8'h00);
    host.start(4'h2);
    foreach (dv[i]) if (i < 3) begin
      host.rd(d);
      chk8(d, i == 2 ? 8'h06 : 8'h00);
    end
    host.finish();
    fast = 1'b0;
    stop_test();
  end
endmodule : tb

`default_nettype wire
